// ===== inc/pb_mux_defs.svh
// register offsets, field positions and reset values of the port B
// override block; included by the block's top design file and by the bench
`ifndef PB_MUX_DEFS_SVH
`define PB_MUX_DEFS_SVH

// register offsets
`define PB_OFS_MCU_CTRL  4'h0
`define PB_OFS_DATA      4'h1
`define PB_OFS_DIR       4'h2
`define PB_OFS_PINS      4'h3
`define PB_OFS_PC_MASK   4'h4
`define PB_OFS_PC_CTRL   4'h5
`define PB_OFS_IRQ_STAT  4'h6
`define PB_OFS_IRQ_CLR   4'h7
`define PB_OFS_IRQ_EN    4'h8

// field positions
`define PB_MCU_PUD_BIT   6
`define PB_MCU_RW_LO     3
`define PB_MCU_RW_HI     6
`define PB_PC_GROUP_BIT  0
`define PB_PC_EXT_IRQ_ZERO_BIT   1

// reset values
`define PB_RST_BYTE      8'h00
`define PB_RST_NIB       4'h0
`define PB_FUSE_PROG     1'b0

`endif

// ===== inc/pb_mux_pkg.sv
// types shared by the port B override block
// assumes nothing beyond a SystemVerilog elaborator
package pb_mux_pkg;

   // clock source selected by the clock fuses
   typedef enum logic [1:0] {
      CLK_INT_RC     = 2'b00,
      CLK_SELECTED_A  = 2'b01,
      CLK_CRYSTAL    = 2'b10,
      CLK_LF_CRYSTAL = 2'b11
   } clk_src_e;

   typedef logic [3:0] pin_vec_t;

endpackage : pb_mux_pkg

// ===== rtl/pin_drive_stage.sv
// one pin's override merge with registered pad controls
// assumes override terms and normal controls on the same clock
`timescale 1ns/1ps
`default_nettype none
module pin_drive_stage
   import pb_mux_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // override terms
   input  wire logic pullup_override_en,
   input  wire logic pullup_override_val,
   input  wire logic dir_override_en,
   input  wire logic dir_override_val,
   input  wire logic outval_override_en,
   input  wire logic outval_override_val,
   input  wire logic din_en_override_en,
   input  wire logic din_en_override_val,
   // normal port controls
   input  wire logic dir_bit,
   input  wire logic out_bit,
   input  wire logic pullup_kill,
   input  wire logic power_down_state,
   // pad controls
   output logic      pull_up,
   output logic      drive_en,
   output logic      drive_val,
   output logic      din_en
);

   logic pu_next;
   logic oe_next;
   logic ov_next;
   logic die_next;

   // normal control unless the override enable is set
   always_comb begin
      pu_next  = pullup_override_en ? pullup_override_val
               : (~dir_bit & out_bit & ~pullup_kill);
      oe_next  = dir_override_en ? dir_override_val : dir_bit;
      ov_next  = outval_override_en ? outval_override_val : out_bit;
      die_next = din_en_override_en ? din_en_override_val
               : ~power_down_state;
   end

   // registered pad controls
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pull_up   <= 1'b0;
         drive_en  <= 1'b0;
         drive_val <= 1'b0;
         din_en    <= 1'b0;
      end else if (ce) begin
         pull_up   <= pu_next;
         drive_en  <= oe_next;
         drive_val <= ov_next;
         din_en    <= die_next;
      end
   end

endmodule : pin_drive_stage
`default_nettype wire

// ===== rtl/port_b_alternate_function_mux.sv
// port B alternate function override logic with register port
// assumes fuse, timer and debug inputs on CORE_CLK; pads asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "pb_mux_defs.svh"
module port_b_alternate_function_mux
   import pb_mux_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   // clock, reset, enable
   input  wire logic              CORE_CLK,
   input  wire logic              RST,
   input  wire logic              CLK_EN,
   // register port
   input  wire logic [ADDR_W-1:0] REG_ADDR,
   input  wire logic [7:0]        REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   output logic      [7:0]        REG_RDATA,
   // fuses, 0 means programmed
   input  wire logic              RESET_DISABLE_FUSE,
   input  wire logic              DEBUG_LINK_FUSE,
   input  wire logic              SYSCLK_OUT_FUSE,
   input  wire logic              LOCK_UNPROG,
   input  wire logic [1:0]        CLK_SRC,
   // chip state
   input  wire logic              SYS_RESET_ACTIVE,
   input  wire logic              POWER_DOWN,
   // timer and debug link
   input  wire logic              CMP_A_EN,
   input  wire logic              CMP_A_LVL,
   input  wire logic              DBG_TX,
   // pads
   input  wire logic [3:0]        PIN_IN,
   output logic      [3:0]        PIN_OUT,
   output logic      [3:0]        PIN_OE,
   output logic      [3:0]        PIN_PULLUP,
   output logic      [3:0]        PIN_DIN_EN,
   output logic      [3:0]        DIN_LEVEL,
   // interrupt
   output logic                   IRQ
);

   //----------------------------------------------------------------
   // declarations
   //----------------------------------------------------------------
   logic [7:0] mcu_control_reg;
   pin_vec_t   data_reg;
   pin_vec_t   dir_reg;
   pin_vec_t   pc_mask_reg;
   logic [1:0] pc_ctrl_reg;
   pin_vec_t   irq_status_reg;
   pin_vec_t   irq_status_next;
   pin_vec_t   irq_enable_reg;
   pin_vec_t   pin_sync1_reg;
   pin_vec_t   pin_sync2_reg;
   pin_vec_t   pin_prev_reg;
   pin_vec_t   pc_event;
   logic       clk_img_reg;
   logic [7:0] rdata_next;
   logic [3:0] addr_lo;
   logic       addr_hit;
   logic       wr_hit;
   clk_src_e   clk_src;
   logic       reset_disable_fuse;
   logic       debug_link_active;
   logic       sysclk_out_fuse;
   logic       crystal_selected;
   logic       selected_a;
   logic       reset_pin_mode;
   logic       pin_change_group1_en;
   logic       ext_irq_zero;
   logic       pullup_kill;
   pin_vec_t   pullup_override_en;
   pin_vec_t   pullup_override_val;
   pin_vec_t   dir_override_en;
   pin_vec_t   dir_override_val;
   pin_vec_t   outval_override_en;
   pin_vec_t   outval_override_val;
   pin_vec_t   din_en_override_en;
   pin_vec_t   din_en_override_val;
   pin_vec_t   src_armed;
   logic       run_en;

   // refuse an address too narrow for the map
   if (ADDR_W < 4) begin : g_addr_check
      $error("ADDR_W must be at least 4");
   end

   //----------------------------------------------------------------
   // fuse and clock decode
   //----------------------------------------------------------------
   always_comb begin
      clk_src = clk_src_e'(CLK_SRC);
      reset_disable_fuse = (RESET_DISABLE_FUSE == `PB_FUSE_PROG);
      // debug needs fuse and open lock
      debug_link_active  = (DEBUG_LINK_FUSE == `PB_FUSE_PROG)
                         & LOCK_UNPROG;
      // clock out by fuse or during reset
      sysclk_out_fuse    = (SYSCLK_OUT_FUSE == `PB_FUSE_PROG)
                         | SYS_RESET_ACTIVE;
      crystal_selected   = (clk_src == CLK_CRYSTAL)
                         | (clk_src == CLK_LF_CRYSTAL);
      selected_a         = (clk_src == CLK_SELECTED_A);
      // reset input only with fuse unprogrammed
      reset_pin_mode     = ~reset_disable_fuse & ~debug_link_active;
      pin_change_group1_en = pc_ctrl_reg[`PB_PC_GROUP_BIT];
      ext_irq_zero       = pc_ctrl_reg[`PB_PC_EXT_IRQ_ZERO_BIT];
      pullup_kill        = mcu_control_reg[`PB_MCU_PUD_BIT];
      src_armed          = pc_mask_reg & {4{pin_change_group1_en}};
      // checks start only on edges seen outside reset
      run_en             = CLK_EN & ~RST;
   end

   //----------------------------------------------------------------
   // override terms per pin
   //----------------------------------------------------------------
   always_comb begin
      pullup_override_en[0]  = selected_a | crystal_selected;
      pullup_override_val[0] = 1'b0;
      dir_override_en[0]     = selected_a | crystal_selected;
      dir_override_val[0]    = 1'b0;
      outval_override_en[0]  = selected_a | crystal_selected;
      outval_override_val[0] = 1'b0;
      din_en_override_en[0]  = selected_a | crystal_selected
                             | src_armed[0];
      din_en_override_val[0] = (selected_a & ~POWER_DOWN)
                             | (~selected_a & ~crystal_selected
                                & src_armed[0]);
      pullup_override_en[1]  = crystal_selected;
      pullup_override_val[1] = 1'b0;
      dir_override_en[1]     = crystal_selected;
      dir_override_val[1]    = 1'b0;
      outval_override_en[1]  = crystal_selected;
      outval_override_val[1] = 1'b0;
      din_en_override_en[1]  = crystal_selected | src_armed[1];
      din_en_override_val[1] = src_armed[1];
      // clock out or compare A on bit 2
      // compare A alone relies on software direction
      pullup_override_en[2]  = sysclk_out_fuse;
      pullup_override_val[2] = 1'b0;
      dir_override_en[2]     = sysclk_out_fuse;
      dir_override_val[2]    = 1'b1;
      outval_override_en[2]  = sysclk_out_fuse | CMP_A_EN;
      outval_override_val[2] = sysclk_out_fuse ? clk_img_reg
                                               : CMP_A_LVL;
      // input kept for interrupt 0 or source 2
      din_en_override_en[2]  = src_armed[2] | ext_irq_zero;
      din_en_override_val[2] = src_armed[2] | ext_irq_zero;
      // bit 3 reset pin, debug link, or pulled-up input when the reset fuse is programmed
      pullup_override_en[3]  = reset_disable_fuse | debug_link_active
                             | reset_pin_mode;
      pullup_override_val[3] = 1'b1;
      dir_override_en[3]     = pullup_override_en[3];
      dir_override_val[3]    = debug_link_active & DBG_TX;
      outval_override_en[3]  = pullup_override_en[3];
      outval_override_val[3] = 1'b0;
      din_en_override_en[3]  = pullup_override_en[3] | src_armed[3];
      din_en_override_val[3] = debug_link_active
                             | (reset_disable_fuse & src_armed[3]);
   end

   //----------------------------------------------------------------
   // pad stages
   //----------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : g_pin
      pin_drive_stage u_stage (
         .clk                 (CORE_CLK),
         .rst                 (RST),
         .ce                  (CLK_EN),
         .pullup_override_en  (pullup_override_en[i]),
         .pullup_override_val (pullup_override_val[i]),
         .dir_override_en     (dir_override_en[i]),
         .dir_override_val    (dir_override_val[i]),
         .outval_override_en  (outval_override_en[i]),
         .outval_override_val (outval_override_val[i]),
         .din_en_override_en  (din_en_override_en[i]),
         .din_en_override_val (din_en_override_val[i]),
         .dir_bit             (dir_reg[i]),
         .out_bit             (data_reg[i]),
         .pullup_kill         (pullup_kill),
         .power_down_state    (POWER_DOWN),
         .pull_up             (PIN_PULLUP[i]),
         .drive_en            (PIN_OE[i]),
         .drive_val           (PIN_OUT[i]),
         .din_en              (PIN_DIN_EN[i])
      );
   end

   //----------------------------------------------------------------
   // clock image and pad synchronisers
   //----------------------------------------------------------------
   // system clock image, toggles each enabled cycle
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) clk_img_reg <= 1'b0;
      else if (CLK_EN) clk_img_reg <= ~clk_img_reg;
   end

   // two-stage pad sync, then previous level
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         pin_sync1_reg <= `PB_RST_NIB;
         pin_sync2_reg <= `PB_RST_NIB;
         pin_prev_reg  <= `PB_RST_NIB;
         DIN_LEVEL     <= `PB_RST_NIB;
      end else if (CLK_EN) begin
         pin_sync1_reg <= PIN_IN;
         pin_sync2_reg <= pin_sync1_reg;
         pin_prev_reg  <= pin_sync2_reg;
         DIN_LEVEL     <= pin_sync2_reg & PIN_DIN_EN;
      end
   end

   //----------------------------------------------------------------
   // register port
   //----------------------------------------------------------------
   always_comb begin
      addr_lo  = REG_ADDR[3:0];
      addr_hit = ((REG_ADDR >> 4) == '0);
      wr_hit   = REG_WR & addr_hit;
   end

   // software-written control registers
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         mcu_control_reg <= `PB_RST_BYTE;
         data_reg        <= `PB_RST_NIB;
         dir_reg         <= `PB_RST_NIB;
         pc_mask_reg     <= `PB_RST_NIB;
         pc_ctrl_reg     <= 2'h0;
         irq_enable_reg  <= `PB_RST_NIB;
      end else if (CLK_EN && wr_hit) begin
         unique case (addr_lo)
            `PB_OFS_MCU_CTRL: mcu_control_reg[`PB_MCU_RW_HI:`PB_MCU_RW_LO]
               <= REG_WDATA[`PB_MCU_RW_HI:`PB_MCU_RW_LO];
            `PB_OFS_DATA:    data_reg       <= REG_WDATA[3:0];
            `PB_OFS_DIR:     dir_reg        <= REG_WDATA[3:0];
            `PB_OFS_PC_MASK: pc_mask_reg    <= REG_WDATA[3:0];
            `PB_OFS_PC_CTRL: pc_ctrl_reg    <= REG_WDATA[1:0];
            `PB_OFS_IRQ_EN:  irq_enable_reg <= REG_WDATA[3:0];
            default: ;
         endcase
      end
   end

   // read mux, data one cycle after the strobe
   always_comb begin
      rdata_next = `PB_RST_BYTE;
      if (addr_hit) begin
         unique case (addr_lo)
            `PB_OFS_MCU_CTRL: rdata_next = mcu_control_reg;
            `PB_OFS_DATA:     rdata_next = {4'h0, data_reg};
            `PB_OFS_DIR:      rdata_next = {4'h0, dir_reg};
            `PB_OFS_PINS:     rdata_next = {4'h0, DIN_LEVEL};
            `PB_OFS_PC_MASK:  rdata_next = {4'h0, pc_mask_reg};
            `PB_OFS_PC_CTRL:  rdata_next = {6'h00, pc_ctrl_reg};
            `PB_OFS_IRQ_STAT: rdata_next = {4'h0, irq_status_reg};
            `PB_OFS_IRQ_EN:   rdata_next = {4'h0, irq_enable_reg};
            default:          rdata_next = `PB_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) REG_RDATA <= `PB_RST_BYTE;
      else if (CLK_EN) REG_RDATA <= REG_RD ? rdata_next : `PB_RST_BYTE;
   end

   //----------------------------------------------------------------
   // pin change events and interrupt
   //----------------------------------------------------------------
   always_comb begin
      pc_event = (pin_sync2_reg ^ pin_prev_reg) & src_armed;
      irq_status_next = irq_status_reg | pc_event;
      if (wr_hit && addr_lo == `PB_OFS_IRQ_CLR)
         irq_status_next = (irq_status_reg & ~REG_WDATA[3:0]) | pc_event;
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         irq_status_reg <= `PB_RST_NIB;
         IRQ            <= 1'b0;
      end else if (CLK_EN) begin
         irq_status_reg <= irq_status_next;
         IRQ            <= |(irq_status_reg & irq_enable_reg);
      end
   end

   //----------------------------------------------------------------
   // assertions
   //----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_read_req;
      run_en && REG_RD && addr_hit && addr_lo == `PB_OFS_DIR;
   endsequence
   sequence s_read_data;
      REG_RDATA == {4'h0, $past(dir_reg)};
   endsequence

   a_osc_in_pin: assert property (
      (run_en && clk_src != CLK_INT_RC) |=>
         !PIN_OE[0] && !PIN_PULLUP[0] && !PIN_OUT[0])
      else $error("bit 0 not held for the oscillator");

   a_rc_plain_io: assert property (
      (run_en && clk_src == CLK_INT_RC && !src_armed[0]) |=>
         PIN_OE[0] == $past(dir_reg[0]) && PIN_DIN_EN[0] == !$past(POWER_DOWN))
      else $error("bit 0 not plain I/O with RC clock");

   a_osc_out_pin: assert property (
      (run_en && crystal_selected) |=> !PIN_OE[1] && !PIN_PULLUP[1])
      else $error("bit 1 not held for the oscillator");

   a_clock_out_drive: assert property (
      (run_en && sysclk_out_fuse) |=>
         PIN_OE[2] && !PIN_PULLUP[2] && PIN_OUT[2] == $past(clk_img_reg))
      else $error("clock not driven on bit 2");

   a_reset_pin_mode: assert property (
      (run_en && reset_pin_mode) |=>
         PIN_PULLUP[3] && !PIN_OE[3] && !PIN_DIN_EN[3])
      else $error("reset pin controls wrong");

   a_debug_open_drain: assert property (
      (run_en && debug_link_active) |=> PIN_PULLUP[3] && !PIN_OUT[3]
         && PIN_OE[3] == $past(DBG_TX) && PIN_DIN_EN[3])
      else $error("debug line not open drain");

   a_ext_irq_zero_input_on: assert property (
      (run_en && ext_irq_zero) |=> PIN_DIN_EN[2])
      else $error("bit 2 input off while interrupt 0 used");

   a_pullup_kill: assert property (
      (run_en && pullup_kill && !sysclk_out_fuse) |=> !PIN_PULLUP[2])
      else $error("pull-up on despite kill bit");

   a_event_sticky: assert property (
      (run_en && pc_event != 4'h0) |=>
         (irq_status_reg & $past(pc_event)) == $past(pc_event))
      else $error("pin change event lost");

   a_irq_level: assert property (
      run_en |=> IRQ == $past(|(irq_status_reg & irq_enable_reg)))
      else $error("interrupt output wrong");

   a_read_timing: assert property (
      s_read_req |=> s_read_data)
      else $error("read data wrong or late");

endmodule : port_b_alternate_function_mux
`default_nettype wire

// ===== tb/board_pads.sv
// board model: pads, pull-ups, floating levels and external drivers
// assumes pad controls from the block on the same clock
`timescale 1ns/1ps
`default_nettype none
module board_pads (
   // clock
   input  wire logic       clk,
   // pad controls from the block
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] pin_pullup,
   // external drivers on the board
   input  wire logic [3:0] ext_en,
   input  wire logic [3:0] ext_val,
   // resolved pad levels
   output logic      [3:0] pin_in
);
   logic float_reg = 1'b0;

   // undriven pads without pull-up change every cycle
   always_ff @(posedge clk) begin
      float_reg <= ~float_reg;
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (pin_oe[i] || ext_en[i])
            pin_in[i] = (!pin_oe[i] | pin_out[i]) & (!ext_en[i] | ext_val[i]);
         else if (pin_pullup[i])
            pin_in[i] = 1'b1;
         else
            pin_in[i] = float_reg ^ i[0];
      end
   end
endmodule : board_pads
`default_nettype wire

// ===== tb/port_b_alternate_function_mux_tb.sv
// self-checking bench for the port B override block
// assumes design files and board model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pb_mux_defs.svh"
module port_b_alternate_function_mux_tb
   import pb_mux_pkg::*;
;
   logic       CORE_CLK = 1'b0, RST = 1'b1, CLK_EN = 1'b1;
   logic [3:0] REG_ADDR = 4'h0;
   logic [7:0] REG_WDATA = 8'h00;
   logic       REG_WR = 1'b0, REG_RD = 1'b0;
   logic       RESET_DISABLE_FUSE = 1'b1, DEBUG_LINK_FUSE = 1'b1;
   logic       SYSCLK_OUT_FUSE = 1'b1, LOCK_UNPROG = 1'b0;
   logic [1:0] CLK_SRC = 2'b00;
   logic       SYS_RESET_ACTIVE = 1'b0, POWER_DOWN = 1'b0;
   logic       CMP_A_EN = 1'b0, CMP_A_LVL = 1'b0, DBG_TX = 1'b0;
   logic [3:0] ext_en = 4'hF, ext_val = 4'h0;
   logic [3:0] PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, PIN_DIN_EN, DIN_LEVEL;
   logic [7:0] REG_RDATA;
   logic       IRQ;
   logic [3:0] m_data = 4'h0, m_dir = 4'h0, m_mask = 4'h0;
   logic       m_grp = 1'b0, m_ext_irq_zero = 1'b0, m_kill = 1'b0;
   logic       t2;
   logic [3:0] e_pu, e_oe, e_out, e_din, c_out, c_din;
   logic [31:0] r, s;
   int         fails = 0, check_count = 0, cyc = 0, seed = 24935;
   logic [3:0] acc_a [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9};
   logic [7:0] acc_e [8] = '{8'h78, 8'h0F, 8'h0F, 8'h0F, 8'h03, 8'h00,
                             8'h0F, 8'h00};

   always #25 CORE_CLK = ~CORE_CLK;

   port_b_alternate_function_mux dut (
      .CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
      .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .RESET_DISABLE_FUSE(RESET_DISABLE_FUSE),
      .DEBUG_LINK_FUSE(DEBUG_LINK_FUSE), .SYSCLK_OUT_FUSE(SYSCLK_OUT_FUSE),
      .LOCK_UNPROG(LOCK_UNPROG), .CLK_SRC(CLK_SRC),
      .SYS_RESET_ACTIVE(SYS_RESET_ACTIVE), .POWER_DOWN(POWER_DOWN),
      .CMP_A_EN(CMP_A_EN), .CMP_A_LVL(CMP_A_LVL), .DBG_TX(DBG_TX),
      .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
      .PIN_PULLUP(PIN_PULLUP), .PIN_DIN_EN(PIN_DIN_EN),
      .DIN_LEVEL(DIN_LEVEL), .IRQ(IRQ));

   board_pads board (
      .clk(CORE_CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE),
      .pin_pullup(PIN_PULLUP), .ext_en(ext_en), .ext_val(ext_val),
      .pin_in(PIN_IN));

   // compare and count
   task automatic chk(input logic [7:0] got, exp, msk);
      check_count++;
      if ((got & msk) !== (exp & msk)) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one write cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
   endtask : wr

   // one read cycle, data checked in the following cycle
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge CORE_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      #1;
      chk(REG_RDATA, e, 8'hFF);
   endtask : rd

   // write port registers, ctl = {kill, ext_irq_zero use, group enable}
   task automatic setregs(input logic [3:0] dat, dir, msk,
                          input logic [2:0] ctl);
      m_data = dat;
      m_dir = dir;
      m_mask = msk;
      {m_kill, m_ext_irq_zero, m_grp} = ctl;
      wr(`PB_OFS_DATA, {4'h0, dat});
      wr(`PB_OFS_DIR, {4'h0, dir});
      wr(`PB_OFS_PC_MASK, {4'h0, msk});
      wr(`PB_OFS_MCU_CTRL, {1'b0, ctl[2], 6'h00});
      wr(`PB_OFS_PC_CTRL, {6'h00, ctl[1:0]});
   endtask : setregs

   // reference pad controls from current inputs and shadow registers
   task automatic expect_pads();
      int ck, xo, ec, dbg, rsd;
      logic [3:0] pc;
      ck = !SYSCLK_OUT_FUSE || SYS_RESET_ACTIVE;
      xo = CLK_SRC[1];
      ec = (CLK_SRC == CLK_SELECTED_A);
      dbg = !DEBUG_LINK_FUSE && LOCK_UNPROG;
      rsd = !RESET_DISABLE_FUSE;
      pc = m_mask & {4{m_grp}};
      e_pu = ~m_dir & m_data & {4{!m_kill}};
      e_oe = m_dir;
      e_out = m_data;
      e_din = {4{!POWER_DOWN}};
      c_out = 4'hF;
      c_din = 4'hF;
      if (ec || xo)
         {e_pu[0], e_oe[0], e_out[0]} = 3'b000;
      if (ec || xo || pc[0])
         e_din[0] = ec ? !POWER_DOWN : (!xo && pc[0]);
      if (xo)
         {e_pu[1], e_oe[1], e_out[1]} = 3'b000;
      if (xo || pc[1])
         e_din[1] = pc[1];
      if (ck)
         {e_pu[2], e_oe[2], c_out[2]} = 3'b010;
      else if (CMP_A_EN)
         e_out[2] = CMP_A_LVL;
      if (m_ext_irq_zero || pc[2])
         e_din[2] = 1'b1;
      e_pu[3] = 1'b1;
      e_oe[3] = dbg && DBG_TX;
      e_out[3] = 1'b0;
      e_din[3] = dbg || (rsd && pc[3]);
   endtask : expect_pads

   // compare pad controls with the reference, PIN_OUT[2] skipped with clock out
   task automatic cmp_pads();
      expect_pads();
      chk(PIN_PULLUP, e_pu, 8'h0F);
      chk(PIN_OE, e_oe, 8'h0F);
      chk(PIN_OUT, e_out, c_out);
      chk(PIN_DIN_EN, e_din, c_din);
   endtask : cmp_pads

   // verdict and end of run
   task automatic test_done();
      $display("mismatches %0d checks %0d", fails, check_count);
      if (fails == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   // cycle ceiling against hangs
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         test_done();
      end
   end

   initial begin
      repeat (20) @(posedge CORE_CLK);
      RST <= 1'b0;
      // reset values, unmapped place included
      for (int a = 0; a < 10; a++)
         if (a != 3)
            rd(a[3:0], 8'h00);
      // access kinds
      foreach (acc_a[k]) begin
         wr(acc_a[k], 8'hFF);
         rd(acc_a[k], acc_e[k]);
         wr(acc_a[k], 8'h00);
      end
      // pin change on sources 0 to 2: raise, mask, clear
      wr(`PB_OFS_IRQ_CLR, 8'h0F);
      wr(`PB_OFS_IRQ_EN, 8'h0F);
      for (int i = 0; i < 3; i++) begin
         setregs(4'h0, 4'h0, 4'h1 << i, 3'b001);
         @(posedge CORE_CLK);
         ext_val[i] <= 1'b1;
         repeat (6) @(posedge CORE_CLK);
         #1;
         chk(IRQ, 8'h01, 8'h01);
         chk(DIN_LEVEL[i], 8'h01, 8'h01);
         rd(`PB_OFS_IRQ_STAT, 8'h01 << i);
         rd(`PB_OFS_PINS, (8'h02 << i) - 8'h01);
         wr(`PB_OFS_IRQ_EN, 8'h00);
         repeat (2) @(posedge CORE_CLK);
         #1;
         chk(IRQ, 8'h00, 8'h01);
         wr(`PB_OFS_IRQ_CLR, 8'h01 << i);
         wr(`PB_OFS_IRQ_EN, 8'h0F);
         rd(`PB_OFS_IRQ_STAT, 8'h00);
      end
      wr(`PB_OFS_IRQ_EN, 8'h00);
      // frozen enable: a write is ignored
      @(posedge CORE_CLK);
      CLK_EN <= 1'b0;
      wr(`PB_OFS_DATA, 8'h05);
      CLK_EN <= 1'b1;
      rd(`PB_OFS_DATA, 8'h00);
      // random fuses, chip state and port settings
      for (int n = 0; n < 40; n++) begin
         r = $random(seed);
         s = $random(seed);
         @(posedge CORE_CLK);
         {RESET_DISABLE_FUSE, DEBUG_LINK_FUSE, SYSCLK_OUT_FUSE, LOCK_UNPROG,
          CLK_SRC, SYS_RESET_ACTIVE, POWER_DOWN, CMP_A_EN, CMP_A_LVL,
          DBG_TX} <= s[10:0];
         {ext_en, ext_val} <= r[23:16];
         setregs(r[3:0], r[7:4] | {1'b0, s[2], 2'b00}, r[11:8], r[14:12]);
         repeat (2) @(posedge CORE_CLK);
         #1;
         cmp_pads();
         // clock image on bit 2 toggles every cycle
         if (!SYSCLK_OUT_FUSE || SYS_RESET_ACTIVE) begin
            t2 = PIN_OUT[2];
            @(posedge CORE_CLK);
            #1;
            chk(PIN_OUT[2], !t2, 8'h01);
         end
      end
      test_done();
   end
endmodule : port_b_alternate_function_mux_tb
`default_nettype wire
